// ===== verilog/scir_sysctl_status.sv
// Purpose: masked event status with write-one-clear, plus reset cause log
// Assumes: event inputs are one-cycle or level pulses synchronous to sys_clk
// Notes: reset-cause log is cleared to CAUSE_POWERUP by raw rst_b, the rest by rstSync_r; causeValid ORs causeIn into it, an extPin cause sets it to 6'h01
`timescale 1ns/1ps

module scir_sysctl_status
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire scir_pkg::scir_event_type eventIn,
    input wire logic causeValid,
    input wire scir_pkg::scir_cause_type causeIn,
    output logic ctrlIrq,
    output logic brownoutResetReq
);

    logic rstMeta_r;
    logic rstSync_r;
    logic [6:0] raw_r;
    logic [6:0] mask_r;
    logic brownout_irq_or_reset_select_r;
    logic [5:0] cause_r;
    logic [6:0] masked;
    logic [6:0] gate;
    logic wrEn;
    logic rdEn;
    logic hit;
    logic [31:0] rdNxt;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // apb strobes, zero wait states
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign hit = (paddr == scir_pkg::OFS_RAW_STATUS)
        || (paddr == scir_pkg::OFS_IRQ_MASK)
        || (paddr == scir_pkg::OFS_MASKED_STATUS)
        || (paddr == scir_pkg::OFS_RESET_CAUSE)
        || (paddr == scir_pkg::OFS_BROWNOUT_CTL);
    assign pslverr = psel && penable && !hit;

    // brownout is an interrupt source only while not routed to reset
    // brownout gating
    always_comb
    begin
        gate = mask_r;
        gate[scir_pkg::BIT_BROWNOUT] = mask_r[scir_pkg::BIT_BROWNOUT]
            && !brownout_irq_or_reset_select_r;
    end

    assign masked = raw_r & gate;
    assign ctrlIrq = |masked;
    assign brownoutResetReq = brownout_irq_or_reset_select_r && eventIn.brownout;

    // raw flags: set beats clear so no event is lost
    always_ff @(posedge sys_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
            raw_r <= scir_pkg::RAW_RESET;
        else
        begin
            if (wrEn && paddr == scir_pkg::OFS_MASKED_STATUS)
                raw_r <= (raw_r & ~pwdata[6:0]) | eventIn;
            else if (wrEn && paddr == scir_pkg::OFS_RAW_STATUS)
                raw_r <= (raw_r & ~pwdata[6:0]) | eventIn;
            else
                raw_r <= raw_r | eventIn;
        end
    end

    // mask and brownout control
    always_ff @(posedge sys_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            mask_r <= scir_pkg::MASK_RESET;
            brownout_irq_or_reset_select_r <= 1'b0;
        end
        else if (wrEn && paddr == scir_pkg::OFS_IRQ_MASK)
            mask_r <= pwdata[6:0];
        else if (wrEn && paddr == scir_pkg::OFS_BROWNOUT_CTL)
            brownout_irq_or_reset_select_r <= pwdata[scir_pkg::BIT_BOR_IOR];
    end

    // cause log on raw rst_b, so it outlives the resets it records
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            cause_r <= scir_pkg::CAUSE_POWERUP;
        else if (causeValid)
        begin
            if (causeIn.extPin)
                cause_r <= 6'h01;
            else
                cause_r <= cause_r | causeIn;
        end
        else if (wrEn && paddr == scir_pkg::OFS_RESET_CAUSE)
            cause_r <= pwdata[5:0];
    end

    // read mux, reserved bits zero
    // reserved read zero
    always_comb
    begin
        rdNxt = 32'h0000_0000;
        case (paddr)
            scir_pkg::OFS_RAW_STATUS: rdNxt[6:0] = raw_r;
            scir_pkg::OFS_IRQ_MASK: rdNxt[6:0] = mask_r;
            scir_pkg::OFS_MASKED_STATUS: rdNxt[6:0] = masked;
            scir_pkg::OFS_RESET_CAUSE: rdNxt[5:0] = cause_r;
            scir_pkg::OFS_BROWNOUT_CTL:
                rdNxt[scir_pkg::BIT_BOR_IOR] = brownout_irq_or_reset_select_r;
            default: rdNxt = 32'h0000_0000;
        endcase
    end

    // read data registered in setup phase
    always_ff @(posedge sys_clk or negedge rstSync_r)
    begin
        if (!rstSync_r)
            prdata <= 32'h0000_0000;
        else if (rdEn)
            prdata <= rdNxt;
    end

endmodule

// ===== verilog/scir_pkg.sv
// Purpose: shared constants and types for the system-control status block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: reserved bits read as zero
package scir_pkg;
    localparam int unsigned EVENT_W = 7;
    localparam int unsigned CAUSE_W = 6;
    // register byte addresses
    localparam logic [11:0] OFS_RAW_STATUS = 12'h0_050;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h0_054;
    localparam logic [11:0] OFS_MASKED_STATUS = 12'h0_058;
    localparam logic [11:0] OFS_RESET_CAUSE = 12'h0_05C;
    localparam logic [11:0] OFS_BROWNOUT_CTL = 12'h0_030;
    // event bit positions
    localparam int unsigned BIT_PLL_LOCK = 6;
    localparam int unsigned BIT_CUR_LIMIT = 5;
    localparam int unsigned BIT_BOOT_OSC = 4;
    localparam int unsigned BIT_MAIN_OSC = 3;
    localparam int unsigned BIT_REG_UNREG = 2;
    localparam int unsigned BIT_BROWNOUT = 1;
    localparam int unsigned BIT_PLL_STOP = 0;
    // reset cause bit positions
    localparam int unsigned CAUSE_REG_PG = 5;
    localparam int unsigned CAUSE_SW = 4;
    localparam int unsigned CAUSE_WDOG = 3;
    localparam int unsigned CAUSE_BROWNOUT = 2;
    localparam int unsigned CAUSE_POR = 1;
    localparam int unsigned CAUSE_EXT = 0;
    // brown-out control bit: 1 = reset, 0 = interrupt
    localparam int unsigned BIT_BOR_IOR = 1;
    localparam logic [6:0] RAW_RESET = 7'h00;
    localparam logic [6:0] MASK_RESET = 7'h00;
    localparam logic [5:0] CAUSE_POWERUP = 6'h02;

    typedef struct packed {
        logic pllLock;
        logic curLimit;
        logic bootOscFault;
        logic mainOscFault;
        logic regUnreg;
        logic brownout;
        logic pllStopped;
    } scir_event_type;

    typedef struct packed {
        logic regPowerGood;
        logic software;
        logic watchdog;
        logic brownout;
        logic powerOn;
        logic extPin;
    } scir_cause_type;
endpackage

// ===== tb/scir_status_properties.sv
// Purpose: port checks for the status block
// Assumes: zero-wait APB slave
// Notes: sees top ports only
`timescale 1ns/1ps
module scir_status_properties
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire scir_pkg::scir_event_type eventIn,
    input wire logic causeValid,
    input wire scir_pkg::scir_cause_type causeIn,
    input wire logic ctrlIrq,
    input wire logic brownoutResetReq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // read data is loaded at the setup edge
    wire rdSet = psel && !penable && !pwrite;
    wire wrAcc = psel && penable && pwrite;
    wire evAny = eventIn != '0;
    a_misc_rsvd: assert property (rdSet && paddr == 12'h058 |=>
        prdata[31:7] == '0) else $error("misc reserved");
    a_cause_rsvd: assert property (rdSet && paddr == 12'h05C |=>
        prdata[31:6] == '0) else $error("cause reserved");
    a_irq_read: assert property (rdSet && paddr == 12'h058 |=>
        (prdata[6:0] != '0) == $past(ctrlIrq)) else $error("irq view");
    a_irq_rise: assert property ($rose(ctrlIrq) |->
        $past(evAny) || $past(wrAcc)) else $error("irq rise");
    a_irq_fall: assert property ($fell(ctrlIrq) |->
        $past(wrAcc)) else $error("irq fall");
    a_bor_req: assert property (brownoutResetReq |->
        eventIn.brownout) else $error("bor request");
    a_bor_hidden: assert property (rdSet && paddr == 12'h058 &&
        brownoutResetReq |=> !prdata[1]) else $error("bor hidden");
    a_cause_ok: assert property (psel && penable &&
        paddr == 12'h05C |-> !pslverr) else $error("cause err");
    a_misc_ok: assert property (psel && penable &&
        paddr == 12'h058 |-> !pslverr) else $error("misc err");
endmodule

bind scir_sysctl_status scir_status_properties u_props (.*);

// ===== tb/tb_scir_sysctl_status.sv
// Purpose: directed register tests
// Assumes: zero-wait APB slave
// Notes: pulses last one clock, except the brown-out event, held for three clocks across one read transfer
`timescale 1ns/1ps
module tb_scir_sysctl_status;
    logic sys_clk = 0;
    logic rst_b = 0;
    logic psel = 0, penable = 0, pwrite = 0, causeValid = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, ctrlIrq, brownoutResetReq, err;
    scir_pkg::scir_event_type eventIn = '0;
    scir_pkg::scir_cause_type causeIn = '0;
    logic [5:0] cv [4] = '{6'h08, 6'h30, 6'h04, 6'h01};
    logic [7:0] ce [4] = '{8'h0A, 8'h3A, 8'h3E, 8'h01};
    int n_fail = 0, n_compared = 0;
    always #50 sys_clk = ~sys_clk;
    scir_sysctl_status u_dut (.*);
    task automatic final_report();
        if (n_fail == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one APB transfer, bounded wait on pready
    task automatic xf(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // request stands until pready is seen high at an edge
        @(posedge sys_clk);
        for (k = 0; k < 9 && pready !== 1'b1; k++)
            @(posedge sys_clk);
        if (k == 9)
            n_fail++;
        if (k == 9)
            final_report();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        xf(0, 12'h05C, '0);
        chk(rd, 32'h0000_0002);
        chk(err, 1'b0);
        // unmapped word reads zero and flags an error
        xf(0, 12'h0FC, '0);
        chk(rd, '0);
        chk(err, 1'b1);
        xf(1, 12'h054, 32'h0000_007F);
        for (int i = 0; i < 7; i++)
        begin
            eventIn <= 7'h01 << i;
            @(posedge sys_clk);
            eventIn <= '0;
            xf(0, 12'h058, '0);
            chk(rd, 32'h1 << i);
            chk(ctrlIrq, 1'b1);
            xf(1, 12'h058, 32'hFFFF_FF80);
            xf(0, 12'h050, '0);
            chk(rd, 32'h1 << i);
            xf(1, 12'h058, 32'h1 << i);
            xf(0, 12'h050, '0);
            chk(rd, '0);
            chk(ctrlIrq, 1'b0);
        end
        // brown-out routed to reset hides the flag
        xf(1, 12'h030, 32'h0000_0002);
        eventIn <= 7'h02;
        xf(0, 12'h058, '0);
        chk(rd, '0);
        chk(brownoutResetReq, 1'b1);
        eventIn <= '0;
        xf(1, 12'h030, '0);
        xf(0, 12'h058, '0);
        chk(rd, 32'h0000_0002);
        // causes accumulate until an external one
        for (int i = 0; i < 4; i++)
        begin
            causeIn <= cv[i];
            causeValid <= 1'b1;
            @(posedge sys_clk);
            causeValid <= 1'b0;
            xf(0, 12'h05C, '0);
            chk(rd, ce[i]);
        end
        xf(1, 12'h05C, '0);
        xf(0, 12'h05C, '0);
        chk(rd, '0);
        final_report();
    end
endmodule
